// File: src/nand_host_cfg.svh
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_COL 8'h08
`define REG_ROW 8'h0c
`define REG_CNT 8'h10
`define REG_DATA 8'h14
`define REG_ID 8'h18
`define REG_GEOM 8'h1c

// control and status field positions
`define CTRL_SKIP_BIT 3
`define STAT_DONE_BIT 1
`define STAT_ERR_BIT 2
`define STAT_FAIL_BIT 3
`define DEV_FAIL_BIT 0
`define DEV_READY_BIT 6

// command bytes
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_ID 8'h90
`define CMD_RND1 8'h05
`define CMD_RND2 8'he0
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hff

// page size in bus words, and identify byte count
`define PAGE_WORDS_X8 2112
`define PAGE_WORDS_X16 1056
`define ID_BYTES 4

// timing
`define CLK_NS 10
`define STB_LO_NS 30
`define STB_HI_NS 30
`define TWB_NS 100
`define TWHR_NS 60
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define STB_LO_CYC `CYC_UP(`STB_LO_NS)
`define STB_HI_CYC `CYC_UP(`STB_HI_NS)
`define TWB_CYC `CYC_UP(`TWB_NS)
`define TWHR_CYC `CYC_UP(`TWHR_NS)
// longest busy wait: program time 700 us
`define BUSY_MAX_US 700
`define BUSY_MAX_CYC (`BUSY_MAX_US * 1000 / `CLK_NS)

`endif

// File: src/nand_host_pkg.sv
`default_nettype none
package nand_host_pkg;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic io_oe;
		logic [15:0] io;
	} nand_out_s;

	typedef struct packed {
		logic rb;
		logic [15:0] io;
	} nand_in_s;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_READ = 3'h1,
		OP_ID = 3'h2,
		OP_RNDOUT = 3'h3,
		OP_PROG = 3'h4,
		OP_RESET = 3'h5,
		OP_STATUS = 3'h6
	} op_e;

	typedef enum logic [2:0] {
		K_CMD = 3'h0,
		K_ADR = 3'h1,
		K_WAIT = 3'h2,
		K_GAP = 3'h3,
		K_RD = 3'h4,
		K_WR = 3'h5,
		K_END = 3'h6
	} kind_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_LOAD = 3'h1,
		S_LO = 3'h2,
		S_HI = 3'h3,
		S_BUSY = 3'h4,
		S_GAP = 3'h5
	} seq_e;

	typedef struct packed {
		kind_e kind;
		logic [7:0] val;
	} item_s;
endpackage : nand_host_pkg
`default_nettype wire

// File: src/nand_host.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "nand_host_cfg.svh"
`default_nettype none

module nand_host #(
	parameter bit BUS16 = 1'b0,
	parameter int NBAD = 8,
	parameter int BUSY_LIMIT = `BUSY_MAX_CYC
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	input wire nand_host_pkg::nand_in_s NAND_I,
	output var nand_host_pkg::nand_out_s NAND_O
);
	import nand_host_pkg::*;

	localparam logic [11:0] PAGE_WORDS = BUS16 ? 12'(`PAGE_WORDS_X16) : 12'(`PAGE_WORDS_X8);
	localparam logic [3:0] LO_CYC = 4'(`STB_LO_CYC);
	localparam logic [3:0] HI_CYC = 4'(`STB_HI_CYC);
	localparam logic [16:0] BUSY_LIM = 17'(BUSY_LIMIT);

	typedef struct packed {
		seq_e st;
		op_e op;
		kind_e kind;
		logic [3:0] step;
		logic [11:0] words;
		logic [3:0] cnt;
		logic [16:0] tmr;
		logic busy;
		logic done;
		logic err;
		logic fail;
		logic rvalid;
		logic wvalid;
		logic last_read;
		logic [11:0] col;
		logic [15:0] row;
		logic [11:0] count;
		logic [15:0] rdata;
		logic [15:0] wdata;
		logic [31:0] id;
		logic [7:0] stat;
		logic [9:0] cur_blk;
		logic [6:0] next_pg;
		logic [NBAD-1:0] bad_v;
		logic [NBAD-1:0][9:0] bad_blk;
		nand_out_s pins;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_s;

	state_s q_r;
	state_s q_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// command sequences, one item per step
	function automatic item_s item_at(input op_e op, input logic [3:0] step,
			input logic [11:0] col, input logic [15:0] row);
		item_s it;
		logic [3:0][7:0] ab;
		it = '{K_END, 8'h00};
		ab[0] = col[7:0];
		ab[1] = BUS16 ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
		ab[2] = row[7:0];
		ab[3] = row[15:8];
		case (op)
			OP_READ: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_READ1};
					4'h1, 4'h2, 4'h3, 4'h4: it = '{K_ADR, ab[2'(step - 4'h1)]};
					4'h5: it = '{K_CMD, `CMD_READ2};
					4'h6: it = '{K_WAIT, 8'h00};
					4'h7: it = '{K_RD, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			OP_ID: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_ID};
					4'h1: it = '{K_ADR, 8'h00};
					4'h2: it = '{K_GAP, 8'h00};
					4'h3: it = '{K_RD, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			OP_RNDOUT: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_RND1};
					4'h1, 4'h2: it = '{K_ADR, ab[2'(step - 4'h1)]};
					4'h3: it = '{K_CMD, `CMD_RND2};
					4'h4: it = '{K_GAP, 8'h00};
					4'h5: it = '{K_RD, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			OP_PROG: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_PROG1};
					4'h1, 4'h2, 4'h3, 4'h4: it = '{K_ADR, ab[2'(step - 4'h1)]};
					4'h5: it = '{K_WR, 8'h00};
					4'h6: it = '{K_CMD, `CMD_PROG2};
					4'h7: it = '{K_WAIT, 8'h00};
					4'h8: it = '{K_CMD, `CMD_STATUS};
					4'h9: it = '{K_GAP, 8'h00};
					4'ha: it = '{K_RD, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			OP_RESET: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_RESET};
					4'h1: it = '{K_WAIT, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			OP_STATUS: begin
				case (step)
					4'h0: it = '{K_CMD, `CMD_STATUS};
					4'h1: it = '{K_GAP, 8'h00};
					4'h2: it = '{K_RD, 8'h00};
					default: it = '{K_END, 8'h00};
				endcase
			end
			default: it = '{K_END, 8'h00};
		endcase
		return it;
	endfunction : item_at

	// decoded geometry from the fourth identify byte
	function automatic logic [31:0] geom(input logic [7:0] b);
		logic [3:0] page_kb;
		logic [8:0] blk_kb;
		logic [4:0] spare;
		logic [6:0] acc_ns;
		case (b[1:0])
			2'h0: page_kb = 4'h1;
			2'h1: page_kb = 4'h2;
			default: page_kb = 4'h0;
		endcase
		case (b[5:4])
			2'h0: blk_kb = 9'h040;
			2'h1: blk_kb = 9'h080;
			2'h2: blk_kb = 9'h100;
			default: blk_kb = 9'h000;
		endcase
		spare = b[2] ? 5'h10 : 5'h08;
		case ({b[7], b[3]})
			2'h0: acc_ns = 7'h32;
			2'h2: acc_ns = 7'h19;
			default: acc_ns = 7'h00;
		endcase
		return {6'h00, acc_ns, b[6], spare, blk_kb, page_kb};
	endfunction : geom

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		item_s it;
		op_e wop;
		logic setup;
		logic complete;
		logic bad_hit;
		logic ord_ok;
		logic cnt_ok;
		logic [9:0] blk;
		logic [5:0] pg;
		it = item_at(q_r.op, q_r.step, q_r.col, q_r.row);
		wop = op_e'(PWDATA[2:0]);
		setup = PSEL & PENABLE & ~q_r.pready;
		complete = PSEL & PENABLE & q_r.pready;
		blk = q_r.row[15:6];
		pg = q_r.row[5:0];
		bad_hit = 1'b0;
		for (int i = 0; i < NBAD; i++) begin
			if (q_r.bad_v[i] && q_r.bad_blk[i] == blk) begin
				bad_hit = 1'b1;
			end
		end
		ord_ok = (pg == 6'h00) || (blk == q_r.cur_blk && {1'b0, pg} == q_r.next_pg);
		cnt_ok = q_r.count != 12'h000 && q_r.count <= PAGE_WORDS;
		q_nxt = q_r;
		q_nxt.pready = 1'b0;
		q_nxt.pslverr = 1'b0;

		// bus answer, one wait state
		if (setup) begin
			q_nxt.pready = 1'b1;
			q_nxt.prdata = 32'h0000_0000;
			case (PADDR)
				`REG_CTRL: begin
					q_nxt.prdata = {29'h0, q_r.op};
					q_nxt.pslverr = PWRITE & q_r.busy;
				end
				`REG_STAT: q_nxt.prdata = {16'h0, q_r.stat, NAND_I.rb, q_r.last_read,
						q_r.wvalid, q_r.rvalid, q_r.fail, q_r.err, q_r.done, q_r.busy};
				`REG_COL: q_nxt.prdata = {20'h0, q_r.col};
				`REG_ROW: q_nxt.prdata = {16'h0, q_r.row};
				`REG_CNT: q_nxt.prdata = {20'h0, q_r.count};
				`REG_DATA: begin
					q_nxt.prdata = {16'h0, q_r.rdata};
					q_nxt.pslverr = PWRITE & q_r.wvalid;
				end
				`REG_ID: q_nxt.prdata = q_r.id;
				`REG_GEOM: q_nxt.prdata = geom(q_r.id[31:24]);
				default: q_nxt.pslverr = 1'b1;
			endcase
		end

		// bus effects at the completing edge
		if (complete && PWRITE) begin
			case (PADDR)
				`REG_CTRL: begin
					if (!q_r.busy) begin
						if (wop == OP_NONE || wop > OP_STATUS
								|| ((wop == OP_READ || wop == OP_RNDOUT || wop == OP_PROG) && !cnt_ok)
								|| (wop == OP_PROG && (bad_hit || !ord_ok))) begin
							q_nxt.err = 1'b1;
						end else begin
							q_nxt.busy = 1'b1;
							q_nxt.op = wop;
							q_nxt.st = S_LOAD;
							q_nxt.step = (wop == OP_READ && PWDATA[`CTRL_SKIP_BIT] && q_r.last_read)
									? 4'h1 : 4'h0;
							q_nxt.words = (wop == OP_ID) ? 12'(`ID_BYTES) :
									(wop == OP_RESET || wop == OP_STATUS) ? 12'h001 : q_r.count;
							q_nxt.last_read = 1'b0;
							if (wop == OP_PROG) begin
								q_nxt.cur_blk = blk;
								q_nxt.next_pg = 7'({1'b0, pg} + 7'h01);
							end
						end
					end
				end
				`REG_STAT: begin
					if (PWDATA[`STAT_DONE_BIT]) q_nxt.done = 1'b0;
					if (PWDATA[`STAT_ERR_BIT]) q_nxt.err = 1'b0;
					if (PWDATA[`STAT_FAIL_BIT]) q_nxt.fail = 1'b0;
				end
				`REG_COL: if (!q_r.busy) q_nxt.col = PWDATA[11:0];
				`REG_ROW: if (!q_r.busy) q_nxt.row = PWDATA[15:0];
				`REG_CNT: if (!q_r.busy) q_nxt.count = PWDATA[11:0];
				`REG_DATA: begin
					if (!q_r.wvalid) begin
						q_nxt.wdata = BUS16 ? PWDATA[15:0] : {8'h00, PWDATA[7:0]};
						q_nxt.wvalid = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (complete && !PWRITE && PADDR == `REG_DATA) begin
			q_nxt.rvalid = 1'b0;
		end

		// pin sequencer; its sets come after the software clears
		case (q_r.st)
			S_IDLE: q_nxt.pins.ce_n = 1'b1;
			S_LOAD: begin
				q_nxt.kind = it.kind;
				q_nxt.cnt = LO_CYC - 4'h1;
				case (it.kind)
					K_CMD, K_ADR: begin
						q_nxt.pins.ce_n = 1'b0;
						q_nxt.pins.cle = (it.kind == K_CMD);
						q_nxt.pins.ale = (it.kind == K_ADR);
						q_nxt.pins.io = {8'h00, it.val};
						q_nxt.pins.io_oe = 1'b1;
						q_nxt.pins.we_n = 1'b0;
						q_nxt.st = S_LO;
					end
					K_WR: begin
						if (q_r.wvalid) begin
							q_nxt.pins.ce_n = 1'b0;
							q_nxt.pins.cle = 1'b0;
							q_nxt.pins.ale = 1'b0;
							q_nxt.pins.io = q_r.wdata;
							q_nxt.pins.io_oe = 1'b1;
							q_nxt.pins.we_n = 1'b0;
							q_nxt.wvalid = 1'b0;
							q_nxt.st = S_LO;
						end else begin
							q_nxt.pins.ce_n = 1'b1;
						end
					end
					K_RD: begin
						if (q_r.rvalid && (q_r.op == OP_READ || q_r.op == OP_RNDOUT)) begin
							q_nxt.pins.ce_n = 1'b1;
						end else begin
							q_nxt.pins.ce_n = 1'b0;
							q_nxt.pins.cle = 1'b0;
							q_nxt.pins.ale = 1'b0;
							q_nxt.pins.io_oe = 1'b0;
							q_nxt.pins.re_n = 1'b0;
							q_nxt.st = S_LO;
						end
					end
					K_WAIT: begin
						q_nxt.cnt = 4'(`TWB_CYC);
						q_nxt.tmr = 17'h00000;
						q_nxt.st = S_BUSY;
					end
					K_GAP: begin
						q_nxt.cnt = 4'(`TWHR_CYC);
						q_nxt.st = S_GAP;
					end
					default: begin
						q_nxt.pins.ce_n = 1'b1;
						q_nxt.busy = 1'b0;
						q_nxt.done = 1'b1;
						q_nxt.last_read = (q_r.op == OP_READ || q_r.op == OP_RNDOUT);
						q_nxt.st = S_IDLE;
						if (q_r.op == OP_PROG && q_r.stat[`DEV_FAIL_BIT]) begin
							q_nxt.fail = 1'b1;
							for (int i = NBAD - 1; i >= 0; i--) begin
								if (!q_r.bad_v[i]) begin
									q_nxt.bad_v = q_r.bad_v | (NBAD'(1) << i);
									q_nxt.bad_blk[i] = blk;
								end
							end
						end
					end
				endcase
			end
			S_LO: begin
				if (q_r.cnt == 4'h0) begin
					if (q_r.kind == K_RD) begin
						case (q_r.op)
							OP_ID: q_nxt.id = {NAND_I.io[7:0], q_r.id[31:8]};
							OP_PROG, OP_STATUS: q_nxt.stat = NAND_I.io[7:0];
							default: begin
								q_nxt.rdata = BUS16 ? NAND_I.io : {8'h00, NAND_I.io[7:0]};
								q_nxt.rvalid = 1'b1;
							end
						endcase
					end
					q_nxt.pins.we_n = 1'b1;
					q_nxt.pins.re_n = 1'b1;
					q_nxt.cnt = HI_CYC - 4'h1;
					q_nxt.st = S_HI;
				end else begin
					q_nxt.cnt = q_r.cnt - 4'h1;
				end
			end
			S_HI: begin
				if (q_r.cnt == 4'h0) begin
					q_nxt.pins.io_oe = 1'b0;
					q_nxt.pins.cle = 1'b0;
					q_nxt.pins.ale = 1'b0;
					if ((q_r.kind == K_RD || q_r.kind == K_WR) && q_r.words > 12'h001) begin
						q_nxt.words = q_r.words - 12'h001;
					end else begin
						// word count survives command and address items
						q_nxt.step = q_r.step + 4'h1;
					end
					q_nxt.st = S_LOAD;
				end else begin
					q_nxt.cnt = q_r.cnt - 4'h1;
				end
			end
			S_BUSY: begin
				q_nxt.tmr = q_r.tmr + 17'h00001;
				if (q_r.cnt != 4'h0) begin
					q_nxt.cnt = q_r.cnt - 4'h1;
				end else if (NAND_I.rb) begin
					q_nxt.step = q_r.step + 4'h1;
					q_nxt.st = S_LOAD;
				end else if (q_r.tmr >= BUSY_LIM) begin
					q_nxt.err = 1'b1;
					q_nxt.step = 4'hf;
					q_nxt.st = S_LOAD;
				end
			end
			S_GAP: begin
				if (q_r.cnt == 4'h0) begin
					q_nxt.step = q_r.step + 4'h1;
					q_nxt.st = S_LOAD;
				end else begin
					q_nxt.cnt = q_r.cnt - 4'h1;
				end
			end
			default: q_nxt.st = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			q_r <= '0;
			q_r.pins.ce_n <= 1'b1;
			q_r.pins.we_n <= 1'b1;
			q_r.pins.re_n <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign PREADY = q_r.pready;
	assign PRDATA = q_r.prdata;
	assign PSLVERR = q_r.pslverr;
	assign NAND_O = q_r.pins;
endmodule : nand_host
`default_nettype wire

// File: test/nand_host_monitor.sv
`include "nand_host_cfg.svh"
`default_nettype none
module nand_host_monitor (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic PREADY,
	input wire logic [31:0] PRDATA,
	input wire logic PSLVERR,
	input wire nand_host_pkg::nand_in_s NAND_I,
	input wire nand_host_pkg::nand_out_s NAND_O
);
	timeunit 1ns;
	timeprecision 1ps;
	import nand_host_pkg::*;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence acc_start;
		PSEL && PENABLE && !$past(PENABLE);
	endsequence
	sequence cmd_latch;
		$rose(NAND_O.we_n) && NAND_O.cle;
	endsequence
	// two more low cycles, then three high
	sequence tail(s);
		(!s) [*2] ##1 s [*3];
	endsequence
	a_ready_wait: assert property (acc_start |-> !PREADY ##1 PREADY)
		else $error("late ready");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("long ready");
	a_unmapped_err: assert property (PREADY && !(PADDR inside {`REG_CTRL, `REG_STAT,
		`REG_COL, `REG_ROW, `REG_CNT, `REG_DATA, `REG_ID, `REG_GEOM})
		|-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access");
	a_upper_zero: assert property ((NAND_O.cle || NAND_O.ale) && NAND_O.io_oe
		|-> NAND_O.io[15:8] == 8'h00) else $error("upper byte set");
	a_latch_excl: assert property (!(NAND_O.cle && NAND_O.ale))
		else $error("both latches");
	a_cmd_hold: assert property (cmd_latch |-> !NAND_O.ce_n && NAND_O.io_oe
		&& $stable(NAND_O.io)) else $error("bad command latch");
	a_write_pulse: assert property ($fell(NAND_O.we_n) |=> tail(NAND_O.we_n))
		else $error("bad write pulse");
	a_read_pulse: assert property ($fell(NAND_O.re_n) |=> tail(NAND_O.re_n))
		else $error("bad read pulse");
	a_read_idle: assert property ($fell(NAND_O.re_n) |-> !NAND_O.ce_n && !NAND_O.io_oe
		&& !NAND_O.cle && !NAND_O.ale) else $error("read while driving");
	a_busy_quiet: assert property (!NAND_I.rb |-> NAND_O.re_n && NAND_O.we_n)
		else $error("strobe while busy");
endmodule : nand_host_monitor
bind nand_host nand_host_monitor u_mon (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA),
	.PSLVERR(PSLVERR), .NAND_I(NAND_I), .NAND_O(NAND_O));
`default_nettype wire

// File: test/nand_dev_model.sv
`include "nand_host_cfg.svh"
`default_nettype none
module nand_dev_model #(
	parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary
	parameter logic [7:0] CHIP_ID = 8'h6a // arbitrary
) (
	input wire nand_host_pkg::nand_out_s nand_o,
	input wire logic fail_next,
	output var nand_host_pkg::nand_in_s nand_i,
	output var int n_read1,
	output var int n_prog
);
	timeunit 1ns;
	timeprecision 1ps;
	import nand_host_pkg::*;
	logic [7:0] mode = `CMD_READ2;
	logic [7:0] stat = 8'he0;
	logic [11:0] col;
	logic [15:0] row;
	logic [7:0] mem [int];
	logic [7:0] ids [4];
	int acnt;
	int idp;
	event busy;
	initial begin
		ids = '{MAKER_ID, CHIP_ID, 8'ha5, 8'h95};
		nand_i = '{rb: 1'b1, io: 16'h5a5a};
		n_read1 = 0;
		n_prog = 0;
	end
	// edges land between host clock edges
	always @(busy) begin
		#17 nand_i.rb = 1'b0;
		#1000 nand_i.rb = 1'b1;
	end
	always @(posedge nand_o.we_n) begin
		if (!nand_o.ce_n && nand_o.cle) begin
			acnt = 0;
			idp = 0;
			case (nand_o.io[7:0])
				`CMD_READ1: n_read1++;
				`CMD_READ2, `CMD_RESET: begin
					mode = `CMD_READ2;
					->busy;
				end
				`CMD_PROG2: begin
					stat[0] = fail_next;
					n_prog++;
					->busy;
				end
				`CMD_ID, `CMD_PROG1, `CMD_STATUS: mode = nand_o.io[7:0];
				default: ;
			endcase
		end else if (!nand_o.ce_n && nand_o.ale) begin
			case (acnt)
				0: col[7:0] = nand_o.io[7:0];
				1: col[11:8] = nand_o.io[3:0];
				2: row[7:0] = nand_o.io[7:0];
				default: row[15:8] = nand_o.io[7:0];
			endcase
			acnt++;
		end else if (!nand_o.ce_n && mode == `CMD_PROG1) begin
			mem[{row, col}] = nand_o.io[7:0];
			col++;
		end
	end
	always @(negedge nand_o.re_n) begin
		if (!nand_o.ce_n) begin
			#12;
			if (mode == `CMD_STATUS) begin
				nand_i.io = {8'h0, stat[7], nand_i.rb, stat[5:0]};
			end else if (mode == `CMD_ID) begin
				nand_i.io = {8'h0, ids[idp]};
				idp++;
			end else begin
				nand_i.io[7:0] = row[7:0] ^ col[7:0] ^ {col[11:8], 4'h9};
				if (mem.exists({row, col})) nand_i.io[7:0] = mem[{row, col}];
				nand_i.io[15:8] = 8'h0;
				col++;
			end
		end
	end
	// released lines show no stale data
	always @(posedge nand_o.re_n) begin
		#14 nand_i.io = ~nand_i.io;
	end
endmodule : nand_dev_model
`default_nettype wire

// File: test/test_nand_host.sv
`include "nand_host_cfg.svh"
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin mismatches++; \
	$display("wrong value at %0t: %h not %h", $time, g, x); end end
module test_nand_host;
	timeunit 1ns;
	timeprecision 1ps;
	import nand_host_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic fail_next = 1'b0;
	nand_in_s n_in;
	nand_out_s n_out;
	int n_read1, n_prog, mismatches = 0, n_compared = 0;
	logic [31:0] q, s;
	logic e;
	logic [15:0] row;
	logic [7:0] ref_mem [int];
	always #5 mclk = ~mclk;
	nand_host #(.BUSY_LIMIT(200)) u_dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
		.PRDATA(prdata), .PSLVERR(pslverr), .NAND_I(n_in), .NAND_O(n_out));
	nand_dev_model u_flash (.nand_o(n_out), .fail_next(fail_next), .nand_i(n_in),
		.n_read1(n_read1), .n_prog(n_prog));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: bus answer missing", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	// wait until any masked status bit is set (v) or all are clear
	task automatic poll(input logic [31:0] m, input logic v);
		int n = 0;
		do begin
			apb(1'b0, `REG_STAT, 32'h0);
			n++;
		end while (((q & m) != 32'h0) !== v && n < 300);
		if (((q & m) != 32'h0) !== v) begin
			mismatches++;
			$display("wrong value at %0t: status wait ran out", $time);
		end
		s = q;
	endtask : poll
	task automatic run(input logic [11:0] c, input int cnt, input logic [31:0] ctl, input int nx);
		logic [11:0] k;
		logic [31:0] d;
		apb(1'b1, `REG_COL, {20'h0, c});
		apb(1'b1, `REG_ROW, {16'h0, row});
		apb(1'b1, `REG_CNT, cnt);
		apb(1'b1, `REG_CTRL, ctl);
		for (int i = 0; i < nx; i++) begin
			k = c + 12'(i);
			if (ctl == 32'h4) begin
				poll(32'h20, 1'b0);
				d = {24'h0, 8'($urandom)};
				ref_mem[{row, k}] = d[7:0];
				apb(1'b1, `REG_DATA, d);
			end else begin
				poll(32'h10, 1'b1);
				apb(1'b0, `REG_DATA, 32'h0);
				d[7:0] = row[7:0] ^ k[7:0] ^ {k[11:8], 4'h9};
				if (ref_mem.exists({row, k})) d[7:0] = ref_mem[{row, k}];
				`CHK(q[7:0], d[7:0])
			end
		end
		poll(32'h6, 1'b1);
		apb(1'b1, `REG_STAT, 32'he);
	endtask : run
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	////////////////////////////////
	initial begin
		void'($urandom(32'h244e));
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, `REG_STAT, 32'h0);
		`CHK(q, 32'h80)
		apb(1'b0, 8'h20, 32'h0);
		`CHK({e, q}, {1'b1, 32'h0})
		row = 16'h0;
		run(12'h0, 4, 32'h2, 0);
		apb(1'b0, `REG_ID, 32'h0);
		`CHK(q, {8'h95, 8'ha5, 8'h6a, 8'h3c})
		apb(1'b0, `REG_GEOM, 32'h0);
		`CHK(q, {6'h0, 7'd25, 1'b0, 5'd16, 9'd128, 4'd2})
		row = 16'($urandom);
		run(12'd2104 - 12'($urandom_range(63)), 8, 32'h1, 8);
		`CHK(n_read1, 1)
		row = 16'($urandom);
		run(12'($urandom_range(2107)), 4, 32'h9, 4);
		`CHK(n_read1, 1)
		repeat (3) run(12'($urandom_range(2108)), 3, 32'h3, 3);
		row = {10'd5, 6'd0};
		run(12'h0, 4, 32'h4, 4);
		`CHK(s[3:2], 2'b00)
		run(12'h0, 4, 32'h1, 4);
		row = {10'd5, 6'd2};
		run(12'h0, 1, 32'h4, 0);
		`CHK({s[2], n_prog}, {1'b1, 32'd1})
		fail_next <= 1'b1;
		row = {10'd5, 6'd1};
		run(12'h0, 2, 32'h4, 2);
		`CHK(s[3], 1'b1)
		fail_next <= 1'b0;
		row = {10'd5, 6'd2};
		run(12'h0, 1, 32'h4, 0);
		`CHK({s[2], n_prog}, {1'b1, 32'd2})
		run(12'h0, 2113, 32'h1, 0);
		`CHK(s[3:1], 3'b010)
		run(12'h0, 1, 32'h6, 0);
		`CHK(s[15:8], 8'he1)
		run(12'h0, 1, 32'h5, 0);
		`CHK(s[3:1], 3'b001)
		final_report();
	end
	initial begin
		#400000;
		mismatches++;
		final_report();
	end
endmodule : test_nand_host
`default_nettype wire
